// *** sbd_pkg.sv ***
`default_nettype none
package sbd_pkg;
    // Register byte offsets on the AXI4-Lite port
    localparam logic [3:0] OFS_DIV = 4'h0;
    localparam logic [3:0] OFS_FRAC = 4'h4;
    localparam logic [3:0] OFS_MODE = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hc;
    // Field positions
    localparam int FRAC_EN_BIT = 6;
    localparam int TAP_LSB = 4;
    localparam int IO_MODE_BIT = 0;
    localparam int DBUF_BIT = 2;
    localparam int STAT_PHASE_LSB = 8;
    localparam int STAT_FRAC_BIT = 16;
    // Values after reset
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [3:0] FRAC_RST = 4'h0;
    localparam logic MODE_RST = 1'b0;
    localparam logic [5:0] PRE_RST = 6'h00;
    // Prescaler tap codes
    localparam logic [1:0] TAP_1 = 2'h0;
    localparam logic [1:0] TAP_4 = 2'h1;
    localparam logic [1:0] TAP_16 = 2'h2;
    localparam logic [1:0] TAP_64 = 2'h3;
    // Prescaler bits that must all be ones for a tap strobe
    localparam logic [5:0] MASK_4 = 6'h03;
    localparam logic [5:0] MASK_16 = 6'h0f;
    localparam logic [5:0] MASK_64 = 6'h3f;
    // Division constants
    localparam logic [3:0] N_CODE_16 = 4'h0;
    localparam logic [4:0] N_FULL = 5'h10;
    localparam logic [4:0] PHASES = 5'h10;
    localparam logic [3:0] PHASE_LAST = 4'hf;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** sbd_div_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sbd_div_if;
    // Configuration towards the divider
    logic tap_strobe;
    logic [3:0] n_code;
    logic [3:0] k;
    logic frac_en;
    // State back from the divider
    logic tick;
    logic [4:0] cnt;
    logic [3:0] phase;
    modport ctrl (
        output tap_strobe, n_code, k, frac_en,
        input tick, cnt, phase
    );
    modport div (
        input tap_strobe, n_code, k, frac_en,
        output tick, cnt, phase
    );
endinterface
`default_nettype wire

// *** sbd_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbd_divider
    import sbd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration and state
    sbd_div_if.div bus
);
    logic [4:0] cnt_reg, cnt_next;
    logic [3:0] phase_reg, phase_next;
    logic tick_reg, tick_next;
    logic [4:0] base_len, per_len;
    logic long_per, fire;
    logic [4:0] seen_reg, seen_next;
    logic armed_reg, armed_next;
    logic [8:0] cfg, cfg_last_reg, cfg_last_next;

    // Period length for the current phase of the 16-period group
    always_comb begin
        base_len = (bus.n_code == N_CODE_16) ? N_FULL
                                             : {1'b0, bus.n_code};
        long_per = bus.frac_en &&
                   ({1'b0, phase_reg} < (PHASES - {1'b0, bus.k}));
        per_len = base_len + {4'h0, long_per};
        // >= so a shortened N takes effect at once instead of wrapping
        fire = bus.tap_strobe && ((cnt_reg + 5'h01) >= per_len);
    end

    // Counter, phase and output tick
    always_comb begin
        cnt_next = cnt_reg;
        phase_next = phase_reg;
        tick_next = 1'b0;
        if (fire) begin
            cnt_next = 5'h00;
            tick_next = 1'b1;
            // Integer mode clears the phase so enabling starts a fresh group
            phase_next = bus.frac_en ? phase_reg + 4'h1 : 4'h0;
        end else if (bus.tap_strobe) begin
            cnt_next = cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 5'h00;
            phase_reg <= 4'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            phase_reg <= phase_next;
            tick_reg <= tick_next;
        end
    end

    assign bus.tick = tick_reg;
    assign bus.cnt = cnt_reg;
    assign bus.phase = phase_reg;

    // Checker state: strobes since last tick, config unchanged since then
    assign cfg = {bus.n_code, bus.k, bus.frac_en};
    always_comb begin
        seen_next = seen_reg;
        armed_next = armed_reg && (cfg == cfg_last_reg);
        cfg_last_next = cfg_last_reg;
        if (fire) begin
            seen_next = 5'h00;
            armed_next = 1'b1;
            cfg_last_next = cfg;
        end else if (bus.tap_strobe) begin
            seen_next = seen_reg + 5'h01;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            seen_reg <= 5'h00;
            armed_reg <= 1'b0;
            cfg_last_reg <= 9'h000;
        end else begin
            seen_reg <= seen_next;
            armed_reg <= armed_next;
            cfg_last_reg <= cfg_last_next;
        end
    end

    AST_INT_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
        fire && armed_reg && cfg == cfg_last_reg && !bus.frac_en
        |-> (seen_reg + 5'h01) == base_len)
        else $error("integer period differs from N");
    AST_N16: assert property (@(posedge clk_i) disable iff (rst_i)
        fire && armed_reg && cfg == cfg_last_reg && !bus.frac_en &&
        bus.n_code == 4'h0 |-> seen_reg == 5'h0f)
        else $error("code zero does not divide by 16");
    AST_FRAC_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
        fire && armed_reg && cfg == cfg_last_reg && bus.frac_en
        |-> (seen_reg + 5'h01) == base_len +
            ((({1'b0, phase_reg} + {1'b0, bus.k}) < 5'h10) ? 5'h01 : 5'h00))
        else $error("fractional period length wrong");
    AST_PHASE_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
        fire && bus.frac_en && phase_reg == PHASE_LAST
        |=> phase_reg == 4'h0 && tick_reg)
        else $error("group of 16 periods does not wrap");
endmodule
`default_nettype wire

// *** sbd_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbd_top
    import sbd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // To the transmit and receive logic of the channel
    output logic baud_tick_o,
    output logic io_mode_o,
    output logic dbuf_en_o
);
    sbd_div_if div_if ();

    // Prescaler state
    logic [5:0] pre_reg, pre_next;
    logic [1:0] tap_sel;
    logic strobe;

    // Register file
    logic [7:0] div_reg, div_next;
    logic [3:0] frac_reg, frac_next;
    logic io_reg, io_next;
    logic dbuf_reg, dbuf_next;

    // Write channel state
    logic aw_have_reg, aw_have_next;
    logic [3:0] aw_addr_reg, aw_addr_next;
    logic w_have_reg, w_have_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic wr_go, wr_ok;
    logic wr_frac;
    logic [3:0] wr_k;
    logic wr_dbuf;

    // Read channel state
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [3:0] rd_addr_reg, rd_addr_next;
    logic [31:0] rd_word;
    logic rd_ok;

    // Free-running prescaler; taps 4, 16 and 64 are derived from one counter
    always_comb begin
        pre_next = pre_reg + 6'h01;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_reg <= PRE_RST;
        end else begin
            pre_reg <= pre_next;
        end
    end

    // Tap strobe: one pulse per 1, 4, 16 or 64 clocks
    assign tap_sel = div_reg[TAP_LSB +: 2];
    always_comb begin
        case (tap_sel)
            TAP_1: strobe = 1'b1;
            TAP_4: strobe = &(pre_reg | ~MASK_4);
            TAP_16: strobe = &(pre_reg | ~MASK_16);
            TAP_64: strobe = &(pre_reg | ~MASK_64);
            default: strobe = 1'b1;
        endcase
    end

    AST_TAP4: assert property (@(posedge clk_i) disable iff (rst_i)
        (strobe && tap_sel == TAP_4) ##1
        (tap_sel == TAP_4 && !strobe) [*3] ##1 (tap_sel == TAP_4)
        |-> strobe)
        else $error("tap 4 strobe not every fourth clock");

    // Divider configuration straight from the registers
    assign div_if.tap_strobe = strobe;
    assign div_if.n_code = div_reg[3:0];
    assign div_if.k = frac_reg;
    assign div_if.frac_en = div_reg[FRAC_EN_BIT];

    sbd_divider u_div (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .bus (div_if.div)
    );

    // Write path: address and data are caught in either order
    assign wr_go = aw_have_reg && w_have_reg;
    assign wr_ok = (aw_addr_reg == OFS_DIV) || (aw_addr_reg == OFS_FRAC) ||
                   (aw_addr_reg == OFS_MODE) || (aw_addr_reg == OFS_STAT);
    always_comb begin
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next = w_have_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (awready_reg && s_axi_awvalid_i) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr_i;
        end
        if (wready_reg && s_axi_wvalid_i) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata_i;
            w_strb_next = s_axi_wstrb_i;
        end
        if (bvalid_reg && s_axi_bready_i) begin
            bvalid_next = 1'b0;
        end
        if (wr_go) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        // Hold both channels off while a response is pending
        awready_next = !aw_have_next && !bvalid_next;
        wready_next = !w_have_next && !bvalid_next;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg <= w_have_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
        end
    end

    // Register update; all fields live in byte lane 0
    always_comb begin
        div_next = div_reg;
        frac_next = frac_reg;
        io_next = io_reg;
        dbuf_next = dbuf_reg;
        if (wr_go && w_strb_reg[0]) begin
            case (aw_addr_reg)
                OFS_DIV: div_next = w_data_reg[7:0];
                OFS_FRAC: frac_next = w_data_reg[3:0];
                OFS_MODE: begin
                    io_next = w_data_reg[IO_MODE_BIT];
                    dbuf_next = w_data_reg[DBUF_BIT];
                end
                default: div_next = div_reg;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_reg <= DIV_RST;
            frac_reg <= FRAC_RST;
            io_reg <= MODE_RST;
            dbuf_reg <= MODE_RST;
        end else begin
            div_reg <= div_next;
            frac_reg <= frac_next;
            io_reg <= io_next;
            dbuf_reg <= dbuf_next;
        end
    end

    assign wr_frac = w_data_reg[FRAC_EN_BIT];
    assign wr_k = w_data_reg[3:0];
    assign wr_dbuf = w_data_reg[DBUF_BIT];

    AST_FRAC_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && aw_addr_reg == OFS_DIV && w_strb_reg[0]
        |=> div_if.frac_en == $past(wr_frac))
        else $error("fractional enable not taken from bit 6");
    AST_K_FIELD: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && aw_addr_reg == OFS_FRAC && w_strb_reg[0]
        |=> div_if.k == $past(wr_k) ##1 $stable(div_if.k))
        else $error("K not taken from fraction control");
    AST_DBUF: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && aw_addr_reg == OFS_MODE && w_strb_reg[0]
        |=> dbuf_en_o == $past(wr_dbuf))
        else $error("double-buffer enable not updated");

    // Read decode; unused bits stay zero
    always_comb begin
        rd_word = 32'h0;
        rd_ok = 1'b1;
        case (s_axi_araddr_i)
            OFS_DIV: rd_word[7:0] = div_reg;
            OFS_FRAC: rd_word[3:0] = frac_reg;
            OFS_MODE: begin
                rd_word[IO_MODE_BIT] = io_reg;
                rd_word[DBUF_BIT] = dbuf_reg;
            end
            OFS_STAT: begin
                rd_word[4:0] = div_if.cnt;
                rd_word[STAT_PHASE_LSB +: 4] = div_if.phase;
                rd_word[STAT_FRAC_BIT] = div_reg[FRAC_EN_BIT];
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // Read channel: one read outstanding, answer one clock after address
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        rd_addr_next = rd_addr_reg;
        if (rvalid_reg && s_axi_rready_i) begin
            rvalid_next = 1'b0;
        end
        if (arready_reg && s_axi_arvalid_i) begin
            rvalid_next = 1'b1;
            rdata_next = rd_word;
            rresp_next = rd_ok ? RESP_OKAY : RESP_SLVERR;
            rd_addr_next = s_axi_araddr_i;
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
            rd_addr_reg <= 4'h0;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            rd_addr_reg <= rd_addr_next;
        end
    end

    AST_RD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        rvalid_reg |-> (rd_addr_reg != OFS_DIV || rdata_reg[31:8] == 24'h0) &&
                       (rd_addr_reg != OFS_FRAC || rdata_reg[31:4] == 28'h0))
        else $error("unused baud register bits read non-zero");

    // Ports come straight from flip-flops
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign baud_tick_o = div_if.tick;
    assign io_mode_o = io_reg;
    assign dbuf_en_o = dbuf_reg;
endmodule
`default_nettype wire

// *** test_serial_baud_rate_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_serial_baud_rate_divider
    import sbd_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] awaddr = 4'h0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [3:0] araddr = 4'h0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic baud_tick;
    logic io_mode;
    logic dbuf_en;
    int err_total = 0;
    int num_checks = 0;
    int iv[32];

    sbd_top dut (
        .clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .baud_tick_o(baud_tick),
        .io_mode_o(io_mode), .dbuf_en_o(dbuf_en)
    );

    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        err_total++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    // Single comparison kind: every result is widened to one word
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
                         input string m);
        num_checks++;
        if (got !== exp) begin
            fail($sformatf("%s got %h exp %h", m, got, exp));
        end
    endtask

    // Handshakes are judged at the falling edge, where the slave's
    // registered outputs are settled until the next rising edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        int n;
        logic aw_hs, w_hs, b_hs;
        logic [1:0] resp;
        b_hs = 1'b0;
        resp = 2'h3;
        @(posedge clk_i);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 200 && !b_hs; n++) begin
            @(negedge clk_i);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid;
            if (b_hs) begin
                resp = bresp;
            end
            @(posedge clk_i);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) bready <= 1'b0;
        end
        if (!b_hs) begin
            fail("write answer missing");
            test_done();
        end
        chk32({30'h0, resp}, {30'h0, er}, "bresp");
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        logic ar_hs, r_hs;
        logic [31:0] d;
        logic [1:0] resp;
        r_hs = 1'b0;
        d = 32'h0;
        resp = 2'h3;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 200 && !r_hs; n++) begin
            @(negedge clk_i);
            ar_hs = arvalid && arready;
            r_hs = rvalid;
            if (r_hs) begin
                d = rdata;
                resp = rresp;
            end
            @(posedge clk_i);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) rready <= 1'b0;
        end
        if (!r_hs) begin
            fail("read answer missing");
            test_done();
        end
        chk32({30'h0, resp}, {30'h0, er}, "rresp");
        chk32(d, ed, "rdata");
    endtask

    // Cycles from the previous sample up to the next tick
    task automatic wait_tick(output int cyc);
        cyc = 0;
        do begin
            @(posedge clk_i);
            #1;
            cyc++;
        end while (baud_tick !== 1'b1 && cyc < 3000);
        if (cyc >= 3000) begin
            fail("no baud tick");
            test_done();
        end
    endtask

    // First periods after a change may be partial, so they are skipped
    task automatic measure(input int num);
        int d;
        repeat (3) wait_tick(d);
        for (int i = 0; i < num; i++) begin
            wait_tick(iv[i]);
        end
    endtask

    task automatic t_reset_values();
        chk32({31'h0, baud_tick}, 32'h0, "tick in reset");
        chk32({30'h0, io_mode, dbuf_en}, 32'h0, "mode in reset");
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_DIV, 32'h0, RESP_OKAY);
        rd(OFS_FRAC, 32'h0, RESP_OKAY);
        rd(OFS_MODE, 32'h0, RESP_OKAY);
    endtask

    task automatic t_registers();
        // Bit 7 and the enable stay low: software keeps bit 7 at zero
        wr(OFS_DIV, 32'hffffff3f, 4'hf, RESP_OKAY);
        rd(OFS_DIV, 32'h0000003f, RESP_OKAY);
        wr(OFS_DIV, 32'h00000012, 4'he, RESP_OKAY);
        rd(OFS_DIV, 32'h0000003f, RESP_OKAY);
        wr(OFS_FRAC, 32'hffffffff, 4'hf, RESP_OKAY);
        rd(OFS_FRAC, 32'h0000000f, RESP_OKAY);
        wr(OFS_MODE, 32'hffffffff, 4'hf, RESP_OKAY);
        rd(OFS_MODE, 32'h00000005, RESP_OKAY);
        chk32({30'h0, io_mode, dbuf_en}, 32'h3, "mode pins");
        wr(4'h2, 32'h00000001, 4'hf, RESP_SLVERR);
        rd(4'h2, 32'h0, RESP_SLVERR);
        wr(OFS_STAT, 32'hffffffff, 4'hf, RESP_OKAY);
        wr(OFS_MODE, 32'h00000004, 4'hf, RESP_OKAY);
        chk32({30'h0, io_mode, dbuf_en}, 32'h1, "dbuf only");
        wr(OFS_DIV, 32'h0, 4'hf, RESP_OKAY);
        wr(OFS_MODE, 32'h0, 4'hf, RESP_OKAY);
        chk32({30'h0, io_mode, dbuf_en}, 32'h0, "mode clear");
    endtask

    // Integer division with K left at a nonzero value it must ignore
    task automatic t_integer();
        logic [7:0] cfg[6] = '{8'h02, 8'h00, 8'h0f, 8'h12, 8'h23, 8'h32};
        int per[6] = '{2, 16, 15, 8, 48, 128};
        wr(OFS_FRAC, 32'h5, 4'hf, RESP_OKAY);
        for (int t = 0; t < 6; t++) begin
            wr(OFS_DIV, {24'h0, cfg[t]}, 4'hf, RESP_OKAY);
            measure(3);
            for (int i = 0; i < 3; i++) begin
                chk32(iv[i], per[t], "period");
            end
        end
        // Divide by one only with I/O interface mode and double buffer
        wr(OFS_MODE, 32'h5, 4'hf, RESP_OKAY);
        wr(OFS_DIV, 32'h01, 4'hf, RESP_OKAY);
        measure(4);
        for (int i = 0; i < 4; i++) begin
            chk32(iv[i], 1, "divide by one");
        end
        // Leave divide by one before UART mode comes back
        wr(OFS_DIV, 32'h02, 4'hf, RESP_OKAY);
        wr(OFS_MODE, 32'h0, 4'hf, RESP_OKAY);
    endtask

    // Fractional division in UART mode; K is written before the enable
    task automatic t_fraction();
        int nv[3] = '{3, 2, 15};
        int kv[3] = '{5, 15, 1};
        int sum, long_n, bad, rise;
        for (int t = 0; t < 3; t++) begin
            wr(OFS_FRAC, kv[t], 4'hf, RESP_OKAY);
            wr(OFS_DIV, 32'h40 | nv[t], 4'hf, RESP_OKAY);
            rd(OFS_DIV, 32'h40 | nv[t], RESP_OKAY);
            measure(16);
            sum = 0;
            long_n = 0;
            bad = 0;
            rise = 0;
            for (int i = 0; i < 16; i++) begin
                sum += iv[i];
                if (iv[i] == nv[t] + 1) long_n++;
                else if (iv[i] != nv[t]) bad++;
                if (iv[i] == nv[t] && iv[(i + 1) % 16] == nv[t] + 1) rise++;
            end
            chk32(sum, 16 * nv[t] + 16 - kv[t], "group length");
            chk32(long_n, 16 - kv[t], "long periods");
            chk32(bad, 0, "odd periods");
            chk32(rise, 1, "long run order");
        end
        // Turning the enable off returns to plain division
        wr(OFS_DIV, 32'h03, 4'hf, RESP_OKAY);
        measure(3);
        for (int i = 0; i < 3; i++) begin
            chk32(iv[i], 3, "after fraction off");
        end
    endtask

    // Guard against a hang anywhere in the run
    initial begin
        #400000;
        fail("run limit reached");
        test_done();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        t_reset_values();
        t_registers();
        t_integer();
        t_fraction();
        test_done();
    end
endmodule
`default_nettype wire
